// [csec_pkg.sv]
// Constants shared by the channel status and error counter bank
package csec_pkg;

    //--------------------------------------------------------------------
    // Register offsets
    //--------------------------------------------------------------------
    localparam logic [7:0]  ADDR_CHANNEL_STATUS    = 8'h0f;
    localparam logic [7:0]  ADDR_HIGH_SIDE_ERR_CNT = 8'h10;
    localparam logic [7:0]  ADDR_LANE_ERR_CNT      = 8'h11;

    //--------------------------------------------------------------------
    // Reset values
    //--------------------------------------------------------------------
    localparam logic [15:0] RST_CHANNEL_STATUS     = 16'h0000;
    localparam logic [15:0] RST_ERR_CNT            = 16'hfffd;
    localparam logic [15:0] CNT_CLEARED            = 16'h0000;
    localparam logic [15:0] CNT_MAX                = 16'hffff;
    localparam logic [15:0] CNT_ONE                = 16'h0001;

    //--------------------------------------------------------------------
    // Status field positions
    //--------------------------------------------------------------------
    localparam int BIT_PATTERN_CHECK_OK      = 15;
    localparam int BIT_LINK_TRAINING_FAILED  = 14;
    localparam int BIT_FAST_SIDE_SIGNAL_LOST = 13;
    localparam int BIT_OFFSET_CAL_DONE       = 12;
    localparam int BIT_GAIN_LOOP_LOCKED      = 11;
    localparam int BIT_FAST_SIDE_WORD_SYNC   = 10;
    localparam int BIT_BAD_CODEWORD_FLAG     = 8;
    localparam int BIT_BITWISE_MARKER_FOUND  = 4;
    localparam int BIT_TRAINING_FRAME_LOCKED = 3;
    localparam int BIT_RECEIVER_TRAINED      = 2;
    localparam int BIT_SLOW_SIDE_PLL_LOCKED  = 1;
    localparam int BIT_FAST_SIDE_PLL_LOCKED  = 0;

    //--------------------------------------------------------------------
    // Latched flag counts and lane count
    //--------------------------------------------------------------------
    localparam int NUM_HIGH_LATCH = 4;  // training fail, LOS, decode, marker
    localparam int NUM_LOW_LATCH  = 5;  // cal, gain, sync, two PLLs
    localparam int NUM_LANES      = 4;

endpackage

// [csec_latch_bits.sv]
// Bank of latched-high or latched-low status flags cleared by a read
`timescale 1ns/1ps
`default_nettype none

module csec_latch_bits #(
    parameter int WIDTH       = 1,
    parameter bit LATCH_HIGH  = 1'b1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] live,
    input  wire logic             readHit,
    output logic      [WIDTH-1:0] latched
);
    import csec_pkg::*;

    //--------------------------------------------------------------------
    // One flag per bit
    //--------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            // The event wins over the read so nothing is lost
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    latched[i] <= 1'b0;
                end else if (live[i] == LATCH_HIGH) begin
                    latched[i] <= LATCH_HIGH;          // [R15]
                end else if (readHit) begin
                    latched[i] <= live[i];             // [R15]
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// [csec_err_counter.sv]
// Saturating 16-bit error counter cleared when read
`timescale 1ns/1ps
`default_nettype none

module csec_err_counter (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        errPulse,
    input  wire logic        readHit,
    output logic      [15:0] count
);
    import csec_pkg::*;

    //--------------------------------------------------------------------
    // Count, saturate, clear on read
    //--------------------------------------------------------------------
    // An error in the read cycle lands as the first count after the clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count <= RST_ERR_CNT;
        end else if (readHit) begin
            count <= errPulse ? CNT_ONE : CNT_CLEARED;      // [R14]
        end else if (errPulse && count != CNT_MAX) begin
            count <= count + CNT_ONE;                       // [R16]
        end
    end

endmodule
`default_nettype wire

// [csec_channel_status.sv]
// Channel status register and the two clear-on-read error counters
//
// Functional notes
// R1 - bit 15 shows pattern checker aligned
// R2 - bit 14 latches link training failure
// R3 - bit 13 latches fast side signal loss
// R4 - bit 12 latched-low offset calibration done
// R5 - bit 11 latched-low gain loop locked
// R6 - bit 10 latched-low fast side sync
// R7 - bit 8 latches bad codeword when valid
// R8 - bit 4 latches marker found when interleaving
// R9 - bit 3 live training frame lock
// R10 - bit 2 live receiver trained
// R11 - bits 1,0 latched-low PLL locks
// R12 - fast counter counts decode, pattern, PRBS errors
// R13 - lane counter counts errors of selected lane
// R14 - counters clear to zero when read
// R15 - latched bits hold until read
// R16 - counters saturate instead of wrapping
`timescale 1ns/1ps
`default_nettype none

module csec_channel_status (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register read port
    input  wire logic        regRead,
    input  wire logic [7:0]  regAddr,
    output logic      [15:0] readData,
    output logic             readValid,
    // Receiver conditions
    input  wire logic        patternCheckOk,
    input  wire logic        linkTrainingFailed,
    input  wire logic        fastSideSignalLost,
    input  wire logic        offsetCalDone,
    input  wire logic        gainLoopLocked,
    input  wire logic        fastSideWordSync,
    input  wire logic        badCodewordFlag,
    input  wire logic        decoderActive,
    input  wire logic        bitwiseMarkerFound,
    input  wire logic        rxBitwiseInterleave,
    input  wire logic        trainingFrameLocked,
    input  wire logic        receiverTrained,
    input  wire logic        slowSidePllLocked,
    input  wire logic        fastSidePllLocked,
    // Error sources
    input  wire logic        testPatternMode,
    input  wire logic        prbsCheckPin,
    input  wire logic        fastDecodeErr,
    input  wire logic        fastPatternErr,
    input  wire logic        fastPrbsErr,
    input  wire logic [2:0]  laneSelectField,
    input  wire logic [3:0]  laneDecodeErr,
    input  wire logic [3:0]  lanePatternErr
);
    import csec_pkg::*;

    //--------------------------------------------------------------------
    // Lane pick, used for both lane error kinds
    //--------------------------------------------------------------------
    function automatic logic pickLane(input logic [3:0] errs,
                                      input logic [2:0] sel);
        logic hit;
        hit = 1'b0;
        if (sel < 3'(NUM_LANES)) begin
            hit = errs[sel[1:0]];
        end
        return hit;
    endfunction

    //--------------------------------------------------------------------
    // Address decode
    //--------------------------------------------------------------------
    logic        stReadHit;
    logic        fastReadHit;
    logic        laneReadHit;

    // Decoding is one level of compare, kept combinational for same-edge clear
    assign stReadHit   = regRead && regAddr == ADDR_CHANNEL_STATUS;
    assign fastReadHit = regRead && regAddr == ADDR_HIGH_SIDE_ERR_CNT;
    assign laneReadHit = regRead && regAddr == ADDR_LANE_ERR_CNT;

    //--------------------------------------------------------------------
    // Latched flags
    //--------------------------------------------------------------------
    logic [NUM_HIGH_LATCH-1:0] highLive;
    logic [NUM_HIGH_LATCH-1:0] highLatched;
    logic [NUM_LOW_LATCH-1:0]  lowLive;
    logic [NUM_LOW_LATCH-1:0]  lowLatched;

    // Qualify events that only mean something in certain modes
    assign highLive = {linkTrainingFailed,                        // [R2]
                       fastSideSignalLost,                        // [R3]
                       badCodewordFlag && decoderActive,          // [R7]
                       bitwiseMarkerFound && rxBitwiseInterleave};// [R8]
    assign lowLive  = {offsetCalDone,                             // [R4]
                       gainLoopLocked,                            // [R5]
                       fastSideWordSync,                          // [R6]
                       slowSidePllLocked,                         // [R11]
                       fastSidePllLocked};                        // [R11]

    csec_latch_bits #(
        .WIDTH      (NUM_HIGH_LATCH),
        .LATCH_HIGH (1'b1)
    ) u_high (
        .clk_sys (clk_sys),
        .rst     (rst),
        .live    (highLive),
        .readHit (stReadHit),
        .latched (highLatched)
    );

    csec_latch_bits #(
        .WIDTH      (NUM_LOW_LATCH),
        .LATCH_HIGH (1'b0)
    ) u_low (
        .clk_sys (clk_sys),
        .rst     (rst),
        .live    (lowLive),
        .readHit (stReadHit),
        .latched (lowLatched)
    );

    //--------------------------------------------------------------------
    // Status word assembly
    //--------------------------------------------------------------------
    logic [15:0] statusVal;

    // Reserved bits read as zero
    always_comb begin
        statusVal = RST_CHANNEL_STATUS;
        statusVal[BIT_PATTERN_CHECK_OK]      = patternCheckOk;      // [R1]
        statusVal[BIT_LINK_TRAINING_FAILED]  = highLatched[3];      // [R2]
        statusVal[BIT_FAST_SIDE_SIGNAL_LOST] = highLatched[2];      // [R3]
        statusVal[BIT_BAD_CODEWORD_FLAG]     = highLatched[1];      // [R7]
        statusVal[BIT_BITWISE_MARKER_FOUND]  = highLatched[0];      // [R8]
        statusVal[BIT_OFFSET_CAL_DONE]       = lowLatched[4];       // [R4]
        statusVal[BIT_GAIN_LOOP_LOCKED]      = lowLatched[3];       // [R5]
        statusVal[BIT_FAST_SIDE_WORD_SYNC]   = lowLatched[2];       // [R6]
        statusVal[BIT_TRAINING_FRAME_LOCKED] = trainingFrameLocked; // [R9]
        statusVal[BIT_RECEIVER_TRAINED]      = receiverTrained;     // [R10]
        statusVal[BIT_SLOW_SIDE_PLL_LOCKED]  = lowLatched[1];       // [R11]
        statusVal[BIT_FAST_SIDE_PLL_LOCKED]  = lowLatched[0];       // [R11]
    end

    //--------------------------------------------------------------------
    // Error counters
    //--------------------------------------------------------------------
    logic        fastErr;
    logic        laneErr;
    logic [15:0] fastCount;
    logic [15:0] laneCount;

    // PRBS pin overrides the mode; test mode swaps decode for pattern errors
    assign fastErr = prbsCheckPin    ? fastPrbsErr :                  // [R12]
                     testPatternMode ? fastPatternErr : fastDecodeErr;
    assign laneErr = testPatternMode                                  // [R13]
                   ? pickLane(lanePatternErr, laneSelectField)
                   : pickLane(laneDecodeErr, laneSelectField);

    csec_err_counter u_fast (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .errPulse (fastErr),
        .readHit  (fastReadHit),
        .count    (fastCount)
    );

    csec_err_counter u_lane (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .errPulse (laneErr),
        .readHit  (laneReadHit),
        .count    (laneCount)
    );

    //--------------------------------------------------------------------
    // Read data capture
    //--------------------------------------------------------------------
    // Snapshot is taken on the same edge the clear happens, so no count is lost
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            readData <= CNT_CLEARED;
        end else if (regRead) begin
            if (stReadHit) begin
                readData <= statusVal;
            end else if (fastReadHit) begin
                readData <= fastCount;                         // [R14]
            end else if (laneReadHit) begin
                readData <= laneCount;                         // [R14]
            end else begin
                readData <= CNT_CLEARED;                       // Unmapped
            end
        end
    end

    // One-cycle mark that readData is fresh
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            readValid <= 1'b0;
        end else begin
            readValid <= regRead;
        end
    end

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    sequence s_losThenQuiet;
        fastSideSignalLost ##1 (!fastSideSignalLost && !stReadHit) [*2];
    endsequence

    property p_pattern_read;
        @(posedge clk_sys) disable iff (rst)
        stReadHit |=> readValid && readData[15] == $past(patternCheckOk);
    endproperty
    a_pattern_read: assert property (p_pattern_read) // [R1]
        else $error("pattern status not read back");

    property p_train_fail;
        @(posedge clk_sys) disable iff (rst)
        linkTrainingFailed |=> statusVal[BIT_LINK_TRAINING_FAILED];
    endproperty
    a_train_fail: assert property (p_train_fail) // [R2]
        else $error("training failure not latched");

    property p_los_hold;
        @(posedge clk_sys) disable iff (rst)
        s_losThenQuiet |-> statusVal[BIT_FAST_SIDE_SIGNAL_LOST];
    endproperty
    a_los_hold: assert property (p_los_hold) // [R3]
        else $error("signal loss flag not held until read");

    property p_cal_low;
        @(posedge clk_sys) disable iff (rst)
        !offsetCalDone ##1 (offsetCalDone && !stReadHit)
            |-> !statusVal[BIT_OFFSET_CAL_DONE];
    endproperty
    a_cal_low: assert property (p_cal_low) // [R4]
        else $error("calibration drop not held low");

    property p_sync_low;
        @(posedge clk_sys) disable iff (rst)
        !fastSideWordSync |=> !statusVal[BIT_FAST_SIDE_WORD_SYNC];
    endproperty
    a_sync_low: assert property (p_sync_low) // [R6]
        else $error("sync drop not latched low");

    property p_decode_gate;
        @(posedge clk_sys) disable iff (rst)
        badCodewordFlag && decoderActive |=> statusVal[BIT_BAD_CODEWORD_FLAG];
    endproperty
    a_decode_gate: assert property (p_decode_gate) // [R7]
        else $error("bad codeword not latched");

    property p_marker_gate;
        @(posedge clk_sys) disable iff (rst)
        !rxBitwiseInterleave && !statusVal[BIT_BITWISE_MARKER_FOUND]
            |=> !statusVal[BIT_BITWISE_MARKER_FOUND];
    endproperty
    a_marker_gate: assert property (p_marker_gate) // [R8]
        else $error("marker flag set without interleave");

    property p_live_bits;
        @(posedge clk_sys) disable iff (rst)
        stReadHit |=> readData[3] == $past(trainingFrameLocked)
                   && readData[2] == $past(receiverTrained);
    endproperty
    a_live_bits: assert property (p_live_bits) // [R9] [R10]
        else $error("live training bits wrong");

    property p_prbs_count;
        @(posedge clk_sys) disable iff (rst)
        prbsCheckPin && fastPrbsErr && !fastReadHit && fastCount != CNT_MAX
            |=> fastCount == $past(fastCount) + CNT_ONE;
    endproperty
    a_prbs_count: assert property (p_prbs_count) // [R12]
        else $error("PRBS error not counted");

    property p_clear_read;
        @(posedge clk_sys) disable iff (rst)
        fastReadHit |=> fastCount <= CNT_ONE
                     && readData == $past(fastCount);
    endproperty
    a_clear_read: assert property (p_clear_read) // [R14]
        else $error("counter not cleared on read");

    property p_saturate;
        @(posedge clk_sys) disable iff (rst)
        laneCount == CNT_MAX && !laneReadHit |=> laneCount == CNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate) // [R16]
        else $error("lane counter wrapped");

    property p_gain_low;
        @(posedge clk_sys) disable iff (rst)
        !gainLoopLocked |=> !statusVal[BIT_GAIN_LOOP_LOCKED];
    endproperty
    a_gain_low: assert property (p_gain_low) // [R5]
        else $error("gain lock drop not latched low");

    property p_pll_low;
        @(posedge clk_sys) disable iff (rst)
        !slowSidePllLocked |=> !statusVal[BIT_SLOW_SIDE_PLL_LOCKED];
    endproperty
    a_pll_low: assert property (p_pll_low) // [R11]
        else $error("slow PLL drop not latched low");

    // A lane select outside the lane range must leave the tally untouched
    property p_lane_idle;
        @(posedge clk_sys) disable iff (rst)
        laneSelectField >= 3'(NUM_LANES) && !laneReadHit
            |=> laneCount == $past(laneCount);
    endproperty
    a_lane_idle: assert property (p_lane_idle) // [R13]
        else $error("lane counter moved with no lane selected");

endmodule
`default_nettype wire

// [csec_host_model.sv]
// Management host model that issues single register reads to the bank
`timescale 1ns/1ps
`default_nettype none

module csec_host_model (
    input  wire logic        clk_sys,
    output logic             regRead,
    output logic      [7:0]  regAddr,
    input  wire logic [15:0] readData,
    input  wire logic        readValid
);
    //--------------------------------------------------------------------
    // Read access
    //--------------------------------------------------------------------
    // Idle request lines from time zero
    initial begin
        regRead = 1'b0;
        regAddr = 8'h00;
    end

    // Called just after a falling edge; the answer lands one cycle later
    task automatic readReg(input logic [7:0] addr,
                           output logic [15:0] data,
                           output logic valid);
        regRead = 1'b1;
        regAddr = addr;
        @(posedge clk_sys);
        @(negedge clk_sys);
        data  = readData;
        valid = readValid;
        regRead = 1'b0;
        // Released address shows garbage, not the last value
        regAddr = ~addr;
    endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench for the channel status and error counter bank
`timescale 1ns/1ps
`default_nettype none

`define CHECK(name, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("ERROR %s expected %h seen %h", name, exp, got); \
        end \
    end

module tb_top;
    import csec_pkg::*;

    //--------------------------------------------------------------------
    // Signals
    //--------------------------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        rst;
    logic        regRead, readValid;
    logic [7:0]  regAddr;
    logic [15:0] readData;
    logic        patternCheckOk, linkTrainingFailed, fastSideSignalLost;
    logic        offsetCalDone, gainLoopLocked, fastSideWordSync;
    logic        badCodewordFlag, decoderActive, bitwiseMarkerFound;
    logic        rxBitwiseInterleave, trainingFrameLocked, receiverTrained;
    logic        slowSidePllLocked, fastSidePllLocked, testPatternMode;
    logic        prbsCheckPin, fastDecodeErr, fastPatternErr, fastPrbsErr;
    logic [2:0]  laneSelectField;
    logic [3:0]  laneDecodeErr, lanePatternErr;
    logic [15:0] data;
    logic        valid;
    int          n_errors = 0;
    int          comparisons = 0;

    always #2.5 clk_sys = ~clk_sys;

    csec_channel_status csec_channel_status_i (
        .clk_sys, .rst, .regRead, .regAddr, .readData, .readValid,
        .patternCheckOk, .linkTrainingFailed, .fastSideSignalLost,
        .offsetCalDone, .gainLoopLocked, .fastSideWordSync,
        .badCodewordFlag, .decoderActive, .bitwiseMarkerFound,
        .rxBitwiseInterleave, .trainingFrameLocked, .receiverTrained,
        .slowSidePllLocked, .fastSidePllLocked, .testPatternMode,
        .prbsCheckPin, .fastDecodeErr, .fastPatternErr, .fastPrbsErr,
        .laneSelectField, .laneDecodeErr, .lanePatternErr
    );

    csec_host_model csec_host_model_i (
        .clk_sys, .regRead, .regAddr, .readData, .readValid
    );

    //--------------------------------------------------------------------
    // Tasks
    //--------------------------------------------------------------------
    // One read plus compare; an idle cycle after keeps strobes apart
    task automatic readExpect(input logic [7:0] addr,
                              input logic [15:0] exp, input string name);
        logic [15:0] got;
        logic        ok;
        csec_host_model_i.readReg(addr, got, ok);
        `CHECK("readValid", 1'b1, ok)
        `CHECK(name, exp, got)
        @(negedge clk_sys);
    endtask

    // Error bursts of distinct lengths so each source is recognisable
    task automatic burst();
        for (int c = 0; c < 9; c++) begin
            fastDecodeErr  = (c < 3);
            fastPatternErr = (c < 5);
            fastPrbsErr    = (c < 7);
            for (int j = 0; j < NUM_LANES; j++) begin
                laneDecodeErr[j]  = (c < j + 1);
                lanePatternErr[j] = (c < j + 5);
            end
            @(negedge clk_sys);
        end
    endtask

    // One-cycle event on a latched-high source with its gate level
    task automatic pulseFlag(input int bitPos, input logic gate);
        decoderActive = gate;
        rxBitwiseInterleave = gate;
        case (bitPos)
            14: linkTrainingFailed = 1'b1;
            13: fastSideSignalLost = 1'b1;
            8: badCodewordFlag = 1'b1;
            default: bitwiseMarkerFound = 1'b1;
        endcase
        @(negedge clk_sys);
        linkTrainingFailed = 1'b0;
        fastSideSignalLost = 1'b0;
        badCodewordFlag = 1'b0;
        bitwiseMarkerFound = 1'b0;
        decoderActive = 1'b0;
        rxBitwiseInterleave = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic test_done();
        $display("Comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    //--------------------------------------------------------------------
    // Watchdog and main sequence
    //--------------------------------------------------------------------
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        $display("ERROR watchdog expected finish seen timeout");
        test_done();
    end

    initial begin
        rst = 1'b1;
        {patternCheckOk, linkTrainingFailed, fastSideSignalLost} = 3'h0;
        {offsetCalDone, gainLoopLocked, fastSideWordSync} = 3'h0;
        {badCodewordFlag, decoderActive, bitwiseMarkerFound} = 3'h0;
        {rxBitwiseInterleave, trainingFrameLocked, receiverTrained} = 3'h0;
        {slowSidePllLocked, fastSidePllLocked, testPatternMode} = 3'h0;
        {prbsCheckPin, fastDecodeErr, fastPatternErr, fastPrbsErr} = 4'h0;
        laneSelectField = 3'h0;
        laneDecodeErr = 4'h0;
        lanePatternErr = 4'h0;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        // Reset values, then clear-on-read and saturation from 0xfffd
        readExpect(ADDR_CHANNEL_STATUS, RST_CHANNEL_STATUS, "status");
        readExpect(ADDR_HIGH_SIDE_ERR_CNT, RST_ERR_CNT, "fastCnt");
        readExpect(ADDR_HIGH_SIDE_ERR_CNT, CNT_CLEARED, "fastCnt");
        laneDecodeErr = 4'h1;
        repeat (5) @(negedge clk_sys);
        laneDecodeErr = 4'h0;
        readExpect(ADDR_LANE_ERR_CNT, CNT_MAX, "laneCnt");
        readExpect(ADDR_LANE_ERR_CNT, CNT_CLEARED, "laneCnt");
        readExpect(8'h12, 16'h0000, "unmapped");
        readExpect(8'h0e, 16'h0000, "unmapped");
        // Error in the read cycle survives the clear as a count of one
        fastDecodeErr = 1'b1;
        csec_host_model_i.readReg(ADDR_HIGH_SIDE_ERR_CNT, data, valid);
        fastDecodeErr = 1'b0;
        `CHECK("readValid", 1'b1, valid)
        `CHECK("fastCnt", CNT_CLEARED, data)
        @(negedge clk_sys);
        readExpect(ADDR_HIGH_SIDE_ERR_CNT, CNT_ONE, "fastCnt");
        // Live bits follow at once, latched-low bits need a reload read
        {patternCheckOk, trainingFrameLocked, receiverTrained} = 3'h7;
        {offsetCalDone, gainLoopLocked, fastSideWordSync} = 3'h7;
        {slowSidePllLocked, fastSidePllLocked} = 2'h3;
        @(negedge clk_sys);
        readExpect(ADDR_CHANNEL_STATUS, 16'h800c, "status");
        readExpect(ADDR_CHANNEL_STATUS, 16'h9c0f, "status");
        gainLoopLocked = 1'b0;
        @(negedge clk_sys);
        gainLoopLocked = 1'b1;
        @(negedge clk_sys);
        readExpect(ADDR_CHANNEL_STATUS, 16'h940f, "status");
        readExpect(ADDR_CHANNEL_STATUS, 16'h9c0f, "status");
        {patternCheckOk, trainingFrameLocked, receiverTrained} = 3'h0;
        @(negedge clk_sys);
        readExpect(ADDR_CHANNEL_STATUS, 16'h1c03, "status");
        {patternCheckOk, trainingFrameLocked, receiverTrained} = 3'h7;
        // Latched-high flags, gated ones tried with the gate off first
        for (int i = 0; i < 6; i++) begin
            int   pos;
            logic gate;
            pos  = (i < 2) ? 14 - i : ((i < 4) ? 8 : 4);
            gate = (i < 2) || i[0];
            pulseFlag(pos, gate);
            readExpect(ADDR_CHANNEL_STATUS, 16'h9c0f | (16'(gate) << pos),
                       "status");
            readExpect(ADDR_CHANNEL_STATUS, 16'h9c0f, "status");
        end
        // Counter source selection by mode, pin and lane
        for (int m = 0; m < 3; m++) begin
            for (int l = 0; l < 5; l++) begin
                testPatternMode = (m != 0);
                prbsCheckPin = (m == 2);
                laneSelectField = l[2:0];
                @(negedge clk_sys);
                burst();
                readExpect(ADDR_HIGH_SIDE_ERR_CNT, 16'(3 + 2 * m),
                           "fastCnt");
                readExpect(ADDR_LANE_ERR_CNT, (l > 3) ? CNT_CLEARED :
                           16'(l + 1 + 4 * (m != 0)), "laneCnt");
            end
        end
        test_done();
    end
endmodule
`default_nettype wire
